// ===== src/stk_cpu_core.sv
/*
 * Fetch and execute sequencer of the stack processor with its bus master
 * port: reset handling, wait states, lane selects, space tags, bus release.
 * Assumes a slave fabric that decodes on strobe AND cycle and that may
 * acknowledge in the same cycle or after any number of wait cycles.
 */
`timescale 1ns/10ps
`default_nettype none

module stk_cpu_core (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic        i_ack,
	input  wire logic [15:0] i_dat,
	output logic             o_cyc,
	output logic             o_stb,
	output logic             o_we,
	output logic      [15:1] o_adr,
	output logic      [1:0]  o_sel,
	output logic      [15:0] o_dat,
	output logic             o_program_space_tag,
	output logic             o_data_space_tag
);
	import stk_pkg::*;

	// ==========================================================
	// State
	// ==========================================================
	stk_state_t  state_reg;
	logic        rst_hold_reg;
	logic [14:0] pc_reg;
	logic [15:0] ir_reg;
	logic [1:0]  slot_reg;

	logic [15:0] stk_x;
	logic [15:0] stk_y;
	logic [15:0] stk_z;

	// ==========================================================
	// Decode of the current slot
	// ==========================================================
	logic [3:0]  cur_op;
	logic        op_bus;
	logic        op_write;
	logic        op_byte;
	logic        op_operand;
	logic        op_jump;
	logic        last_slot;

	assign cur_op = slot_op(ir_reg, slot_reg);

	// Only the literal and memory opcodes touch the bus; the rest run stack-only
	always_comb begin
		op_bus     = 1'b0;
		op_write   = 1'b0;
		op_byte    = 1'b0;
		op_operand = 1'b0;
		case (cur_op)
			OP_LIT: begin
				op_bus     = 1'b1;
				op_operand = 1'b1;
			end
			OP_FWM: begin
				op_bus = 1'b1;
			end
			OP_SWM: begin
				op_bus   = 1'b1;
				op_write = 1'b1;
			end
			OP_FBM: begin
				op_bus  = 1'b1;
				op_byte = 1'b1;
			end
			OP_SBM: begin
				op_bus   = 1'b1;
				op_write = 1'b1;
				op_byte  = 1'b1;
			end
			default: begin
				op_bus = 1'b0;
			end
		endcase
	end

	// Taken branches discard the rest of the word
	always_comb begin
		case (cur_op)
			OP_GO:   op_jump = 1'b1;
			OP_ZGO:  op_jump = (stk_y == ZERO_WORD);
			OP_NZGO: op_jump = (stk_y != ZERO_WORD);
			default: op_jump = 1'b0;
		endcase
	end

	// Trailing no-ops are skipped, so they cost no cycles
	assign last_slot = (slot_reg == LAST_SLOT) || rest_idle(ir_reg, slot_reg);

	// ==========================================================
	// Bus request and progress
	// ==========================================================
	logic in_fetch;
	logic in_exec;
	logic bus_req;
	logic advance;

	assign in_fetch = (state_reg == STK_ST_FETCH);
	assign in_exec  = (state_reg == STK_ST_EXEC);
	assign bus_req  = in_fetch || (in_exec && op_bus);

	// A pending transfer stalls everything; with no request, always move on
	assign advance  = !bus_req || i_ack;

	// ==========================================================
	// Byte lanes
	// ==========================================================
	logic [15:0] eff_addr;
	logic [1:0]  lane_sel;
	logic [15:0] lane_wr;
	logic [15:0] lane_load;
	logic [15:0] load_data;

	// Fetches and operands use the program counter, data accesses use Z
	assign eff_addr = (in_fetch || op_operand) ? {pc_reg, 1'b0} : stk_z;

	stk_lanes u_lanes (
		.i_addr   (eff_addr),
		.i_byte   (in_exec && op_byte),
		.i_store  (stk_y),
		.i_bus_rd (i_dat),
		.o_sel    (lane_sel),
		.o_bus_wr (lane_wr),
		.o_load   (lane_load)
	);

	// Read data only enters the stack on a read strobe
	assign load_data = (bus_req && !op_write) ? lane_load : ZERO_WORD;

	// ==========================================================
	// Parameter stack
	// ==========================================================
	logic stack_step;

	// Stack moves once per completed execution slot, never while frozen
	assign stack_step = in_exec && advance;

	stk_stack u_stack (
		.i_clk_sys (i_clk_sys),
		.i_step    (stack_step),
		.i_op      (cur_op),
		.i_load    (load_data),
		.o_x       (stk_x),
		.o_y       (stk_y),
		.o_z       (stk_z)
	);

	// ==========================================================
	// Reset stretch
	// ==========================================================
	// Holds reset effect for one edge after release of the input
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			rst_hold_reg <= 1'b1;
		end else begin
			rst_hold_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Sequencer
	// ==========================================================
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= STK_ST_RESET;
		end else begin
			case (state_reg)
				STK_ST_RESET: begin
					if (!rst_hold_reg) begin
						state_reg <= STK_ST_FETCH;
					end
				end
				STK_ST_FETCH: begin
					// An all no-op word fetches again at once
					if (i_ack && (i_dat != ZERO_WORD)) begin
						state_reg <= STK_ST_EXEC;
					end
				end
				STK_ST_EXEC: begin
					if (advance && (op_jump || last_slot)) begin
						state_reg <= STK_ST_FETCH;
					end
				end
				default: begin
					state_reg <= STK_ST_RESET;
				end
			endcase
		end
	end

	// Slot pointer walks from the top nibble downward
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			slot_reg <= FIRST_SLOT;
		end else if (in_fetch) begin
			slot_reg <= FIRST_SLOT;
		end else if (in_exec && advance && !last_slot) begin
			slot_reg <= slot_reg + SLOT_STEP;
		end
	end

	// Instruction register loads on the acknowledged fetch only
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			ir_reg <= ZERO_WORD;
		end else if (in_fetch && i_ack) begin
			ir_reg <= i_dat;
		end
	end

	// ==========================================================
	// Program counter
	// ==========================================================
	// Points at the next literal or instruction word; bit 0 is always zero
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			pc_reg <= RESET_PC;
		end else if (state_reg == STK_ST_RESET) begin
			pc_reg <= RESET_PC;
		end else if (in_fetch && i_ack) begin
			pc_reg <= pc_reg + PC_STEP;
		end else if (in_exec && advance) begin
			if (cur_op == OP_LIT) begin
				pc_reg <= pc_reg + PC_STEP;
			end else if (op_jump) begin
				pc_reg <= stk_z[15:1];
			end
		end
	end

	// ==========================================================
	// Bus outputs
	// ==========================================================
	// One transfer per transaction, so cycle and strobe are one signal
	assign o_cyc = bus_req;
	assign o_stb = bus_req;

	// Word address from the effective byte address, held while waiting
	assign o_adr = eff_addr[15:1];

	// Direction is read in fetch, write only for stores
	assign o_we  = in_exec && op_write;

	// Lanes only meaningful under the strobe; quiet otherwise
	assign o_sel = bus_req ? lane_sel : SEL_NONE;

	// Store data stays put until the acknowledged edge, since Y is frozen
	assign o_dat = (in_exec && op_write) ? lane_wr : ZERO_WORD;

	// Space tags: fetch 10, operand 11, data 01, idle 00
	assign o_program_space_tag = in_fetch || (in_exec && op_operand);
	assign o_data_space_tag    = in_exec && op_bus;

endmodule

`default_nettype wire

// ===== src/stk_lanes.sv
/*
 * Byte lane steering for the bus master port: lane selects, store data
 * placement and load data extraction for word and byte accesses.
 * Purely combinational; the caller qualifies everything with the strobe.
 */
`timescale 1ns/10ps
`default_nettype none

module stk_lanes (
	input  wire logic [15:0] i_addr,
	input  wire logic        i_byte,
	input  wire logic [15:0] i_store,
	input  wire logic [15:0] i_bus_rd,
	output logic      [1:0]  o_sel,
	output logic      [15:0] o_bus_wr,
	output logic      [15:0] o_load
);
	import stk_pkg::*;

	// Byte accesses pick the lane from address bit 0, little-endian
	always_comb begin
		if (i_byte) begin
			o_sel    = i_addr[0] ? SEL_HI : SEL_LO;
			o_bus_wr = {i_store[7:0], i_store[7:0]};
			o_load   = i_addr[0] ? {ZERO_BYTE, i_bus_rd[15:8]}
			                     : {ZERO_BYTE, i_bus_rd[7:0]};
		end else begin
			o_sel    = SEL_WORD;
			o_bus_wr = i_store;
			o_load   = i_bus_rd;
		end
	end

endmodule

`default_nettype wire

// ===== src/stk_pkg.sv
/*
 * Shared constants, opcodes, sequencer states and slot helpers for the
 * small 16-bit stack processor bus master port.
 * Assumes a single clock domain and a Wishbone-style slave fabric outside.
 */

package stk_pkg;

	// ==========================================================
	// Widths and reset values
	// ==========================================================
	localparam int          DATA_W      = 16;
	localparam int          PC_W        = 15;
	localparam logic [14:0] RESET_PC    = 15'h0000;
	localparam logic [14:0] PC_STEP     = 15'h0001;   // One word, two bytes
	localparam logic [1:0]  FIRST_SLOT  = 2'h0;
	localparam logic [1:0]  LAST_SLOT   = 2'h3;
	localparam logic [1:0]  SLOT_STEP   = 2'h1;
	localparam logic [15:0] ZERO_WORD   = 16'h0000;
	localparam logic [7:0]  ZERO_BYTE   = 8'h00;

	// ==========================================================
	// Byte lane selects
	// ==========================================================
	localparam logic [1:0]  SEL_WORD    = 2'h3;
	localparam logic [1:0]  SEL_HI      = 2'h2;
	localparam logic [1:0]  SEL_LO      = 2'h1;
	localparam logic [1:0]  SEL_NONE    = 2'h0;

	// ==========================================================
	// Opcodes
	// ==========================================================
	localparam logic [3:0]  OP_NOP      = 4'h0;
	localparam logic [3:0]  OP_LIT      = 4'h1;   // literal_push_op
	localparam logic [3:0]  OP_FWM      = 4'h2;
	localparam logic [3:0]  OP_SWM      = 4'h3;
	localparam logic [3:0]  OP_ADD      = 4'h4;
	localparam logic [3:0]  OP_AND      = 4'h5;
	localparam logic [3:0]  OP_XOR      = 4'h6;
	localparam logic [3:0]  OP_ZGO      = 4'h7;
	localparam logic [3:0]  OP_FBM      = 4'hA;
	localparam logic [3:0]  OP_SBM      = 4'hB;
	localparam logic [3:0]  OP_GO       = 4'hE;
	localparam logic [3:0]  OP_NZGO     = 4'hF;

	// ==========================================================
	// Sequencer states
	// ==========================================================
	typedef enum logic [1:0] {
		STK_ST_RESET,
		STK_ST_FETCH,
		STK_ST_EXEC
	} stk_state_t;

	// ==========================================================
	// Slot helpers
	// ==========================================================
	// Opcode in a slot, slot 0 being the top nibble
	function automatic logic [3:0] slot_op(input logic [15:0] word, input logic [1:0] slot);
		logic [3:0] op;
		op = 4'h0;
		case (slot)
			2'h0: op = word[15:12];
			2'h1: op = word[11:8];
			2'h2: op = word[7:4];
			default: op = word[3:0];
		endcase
		return op;
	endfunction

	// True when every slot after the given one holds a no-op
	function automatic logic rest_idle(input logic [15:0] word, input logic [1:0] slot);
		logic idle;
		idle = 1'b1;
		case (slot)
			2'h0: idle = (word[11:0] == 12'h000);
			2'h1: idle = (word[7:0] == 8'h00);
			2'h2: idle = (word[3:0] == 4'h0);
			default: idle = 1'b1;
		endcase
		return idle;
	endfunction

endpackage

// ===== src/stk_stack.sv
/*
 * Three-cell parameter stack with its ALU. Cells carry no reset, so their
 * contents are undefined until software loads them.
 * Assumes the caller raises i_step only in a cycle where the op completes.
 */
`timescale 1ns/10ps
`default_nettype none

module stk_stack (
	input  wire logic        i_clk_sys,
	input  wire logic        i_step,
	input  wire logic [3:0]  i_op,
	input  wire logic [15:0] i_load,
	output logic      [15:0] o_x,
	output logic      [15:0] o_y,
	output logic      [15:0] o_z
);
	import stk_pkg::*;

	logic [15:0] x_reg;
	logic [15:0] y_reg;
	logic [15:0] z_reg;
	logic [15:0] x_next;
	logic [15:0] y_next;
	logic [15:0] z_next;

	assign o_x = x_reg;
	assign o_y = y_reg;
	assign o_z = z_reg;

	// Next stack contents per opcode; pops keep X as the fill value
	always_comb begin
		x_next = x_reg;
		y_next = y_reg;
		z_next = z_reg;
		case (i_op)
			OP_LIT: begin
				x_next = y_reg;
				y_next = z_reg;
				z_next = i_load;
			end
			OP_FWM, OP_FBM: begin
				z_next = i_load;
			end
			OP_SWM, OP_SBM, OP_ZGO, OP_NZGO: begin
				y_next = x_reg;
				z_next = x_reg;
			end
			OP_ADD: begin
				y_next = x_reg;
				z_next = z_reg + y_reg;
			end
			OP_AND: begin
				y_next = x_reg;
				z_next = z_reg & y_reg;
			end
			OP_XOR: begin
				y_next = x_reg;
				z_next = z_reg ^ y_reg;
			end
			OP_GO: begin
				y_next = x_reg;
				z_next = y_reg;
			end
			default: begin
			end
		endcase
	end

	// No reset on data cells: saves area, and software must initialise them
	always_ff @(posedge i_clk_sys) begin
		if (i_step) begin
			x_reg <= x_next;
			y_reg <= y_next;
			z_reg <= z_next;
		end
	end

endmodule

`default_nettype wire

// ===== testbench/stk_cpu_core_sva.sv
/*
 * Checker for the bus port of the stack processor core.
 * Sees only the core's ports; bound to every instance of the core.
 */
`timescale 1ns/10ps
`default_nettype none

module stk_cpu_core_chk (
	input wire logic        i_clk_sys,
	input wire logic        i_rst,
	input wire logic        i_ack,
	input wire logic [15:0] i_dat,
	input wire logic        o_cyc,
	input wire logic        o_stb,
	input wire logic        o_we,
	input wire logic [15:1] o_adr,
	input wire logic [1:0]  o_sel,
	input wire logic [15:0] o_dat,
	input wire logic        o_program_space_tag,
	input wire logic        o_data_space_tag
);
	// ==========================================================
	// Helpers
	// ==========================================================
	logic       fch;
	logic [2:0] xc_reg;
	assign fch = o_stb && o_program_space_tag && !o_data_space_tag;

	// Cycles since the last fetch; wait cycles do not count, saturates
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			xc_reg <= 3'h0;
		end else if (fch) begin
			xc_reg <= 3'h0;
		end else if (!(o_stb && !i_ack) && xc_reg != 3'h7) begin
			xc_reg <= xc_reg + 3'h1;
		end
	end

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	// ==========================================================
	// Sequences and properties
	// ==========================================================
	sequence s_wait;
		o_stb && !i_ack;
	endsequence
	sequence s_prog_done;
		o_stb && i_ack && o_program_space_tag;
	endsequence
	sequence s_first_fetch;
		fch && !o_we && o_adr == 15'h0 && o_sel == 2'h3;
	endsequence

	property p_cyc_stb;
		o_cyc == o_stb;
	endproperty
	property p_no_ptag_wr;
		o_stb && o_we |-> !o_program_space_tag;
	endproperty
	property p_tags_stb;
		o_stb == (o_program_space_tag || o_data_space_tag);
	endproperty
	property p_hold;
		s_wait |=> o_stb && $stable(o_adr)
			&& $stable({o_we, o_sel, o_dat, o_program_space_tag, o_data_space_tag});
	endproperty
	property p_reset_fetch;
		$fell(i_rst) |-> !o_stb ##1 !o_stb ##1 s_first_fetch;
	endproperty
	property p_fetch_word;
		o_stb && o_program_space_tag |-> o_sel == 2'h3;
	endproperty
	property p_prog_step;
		s_prog_done ##1 (o_stb && o_program_space_tag) |-> o_adr == $past(o_adr) + 15'h1;
	endproperty
	property p_exec_bound;
		xc_reg <= 3'h4;
	endproperty

	a_cyc_stb:     assert property (p_cyc_stb)     else $error("cyc and stb differ");
	a_no_ptag_wr:  assert property (p_no_ptag_wr)  else $error("program tag on write");
	a_tags_stb:    assert property (p_tags_stb)    else $error("tags disagree with stb");
	a_hold:        assert property (p_hold)        else $error("wait state not held");
	a_reset_fetch: assert property (p_reset_fetch) else $error("bad fetch after reset");
	a_fetch_word:  assert property (p_fetch_word)  else $error("program access not word");
	a_prog_step:   assert property (p_prog_step)   else $error("program address skipped");
	a_exec_bound:  assert property (p_exec_bound)  else $error("over four exec cycles");
endmodule

bind stk_cpu_core stk_cpu_core_chk CHK (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ack(i_ack),
	.i_dat(i_dat), .o_cyc(o_cyc), .o_stb(o_stb), .o_we(o_we), .o_adr(o_adr), .o_sel(o_sel),
	.o_dat(o_dat), .o_program_space_tag(o_program_space_tag),
	.o_data_space_tag(o_data_space_tag));

`default_nettype wire

// ===== testbench/stk_cpu_core_tb.sv
/*
 * Self-checking bench for the processor bus port.
 * Assumes the memory model as slave; traces the first 18 advancing cycles.
 */
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
	$display("ERROR at %0t: got %0h, expected %0h", $time, (a), (e)); end end

module stk_cpu_core_tb;
	// Trace codes: {stb, we, ptag, dtag, sel}, then the word address
	localparam logic [5:0]  F = 6'b101011;
	localparam logic [5:0]  O = 6'b101111;
	localparam logic [5:0]  W = 6'b110111;
	localparam logic [5:0]  B = 6'b110110;
	localparam logic [5:0]  R = 6'b100110;
	localparam logic [15:0] PROG [11] = '{16'h1130, 16'hBEEF, 16'h0200, 16'h11B0, 16'h00A5,
		16'h0201, 16'h1A40, 16'h0201, 16'h0000, 16'h01E0, 16'h0018};
	localparam logic [20:0] EXP [18] = '{{F,15'h0}, {O,15'h1}, {O,15'h2}, {W,15'h100},
		{F,15'h3}, {O,15'h4}, {O,15'h5}, {B,15'h100}, {F,15'h6}, {O,15'h7}, {R,15'h100},
		21'h0, {F,15'h8}, {F,15'h9}, 21'h0, {O,15'hA}, 21'h0, {F,15'hC}};
	// Second program: word load, AND, XOR, four-slot words, both branch kinds taken
	// and not taken; a wrong branch lands on a store that spoils word 0x101
	localparam logic [15:0] P2 [22] = '{16'h1112, 16'h0F0F, 16'h3C3C, 16'h0200, 16'h5613,
		16'h0202, 16'h171F, 16'h0012, 16'h0016, 16'h1300, 16'h0202, 16'h11F0, 16'h0000,
		16'h0012, 16'h1170, 16'h0000, 16'h0026, 16'h1300, 16'h0202, 16'h1130, 16'h1234,
		16'h0204};

	logic        clk;
	logic        rst;
	logic        ack;
	logic [15:0] rdat;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [15:1] adr;
	logic [1:0]  sel;
	logic [15:0] dat;
	logic        pt;
	logic        dt;
	logic [3:0]  n_waits;
	logic        st;
	logic [20:0] got [$];
	int          n_fail;
	int          comparisons;

	stk_cpu_core DUT (.i_clk_sys(clk), .i_rst(rst), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc),
		.o_stb(stb), .o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(dat),
		.o_program_space_tag(pt), .o_data_space_tag(dt));

	stk_wb_mem MEM (.i_clk_sys(clk), .i_cyc(cyc), .i_stb(stb), .i_we(we), .i_adr(adr),
		.i_sel(sel), .i_dat(dat), .i_waits(n_waits), .o_ack(ack), .o_dat(rdat));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Trace advancing cycles from the first request; wait cycles are skipped
	// Sole owner of the trace state, so reset clears it here
	always @(posedge clk) begin
		if (rst) begin
			st = 1'b0;
			got.delete();
		end else begin
			if (stb) st = 1'b1;
			if (st && (!stb || ack) && got.size() < 18) begin
				got.push_back(stb ? {1'b1, we, pt, dt, sel, adr} : 21'h0);
			end
		end
	end

	task automatic results();
		$display("Comparisons %0d, failures %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Reset, reload the program, time the first fetch
	task automatic t_reset(input logic [3:0] w, input logic alt);
		int n;
		@(posedge clk);
		#1 rst = 1'b1;
		n_waits = w;
		repeat (6) @(posedge clk);
		#1;
		`CHK({cyc, stb, we, pt, dt, sel, dat}, 23'h0)
		foreach (MEM.mem[i]) begin
			MEM.mem[i] = (alt && i < 22) ? P2[i] : (!alt && i < 11) ? PROG[i] : 16'h0000;
		end
		if (alt) MEM.mem[9'h100] = 16'h00FF;
		rst = 1'b0;
		n = 0;
		while (!stb && n < 10) begin
			@(posedge clk);
			#1 n++;
		end
		`CHK(n, 2)
		`CHK({adr, pt, dt, sel}, {15'h0, 4'hB})
		if (n >= 10) results();
	endtask

	// Run the program with the given waits and judge the trace
	task automatic t_run(input logic [3:0] w);
		int n;
		t_reset(w, 1'b0);
		n = 0;
		while (got.size() < 18 && n < 500) begin
			@(posedge clk);
			n++;
		end
		if (got.size() < 18) begin
			n_fail++;
			results();
		end
		#1;
		foreach (EXP[i]) `CHK(got[i], EXP[i])
		`CHK(MEM.mem[9'h100], 16'hA5EF)
	endtask

	// Second program with no waits: 27 cycles from the first fetch to the last store
	task automatic t_alu();
		int n;
		t_reset(4'h0, 1'b1);
		n = 0;
		while (MEM.mem[9'h102] !== 16'h1234 && n < 200) begin
			@(posedge clk);
			#1 n++;
		end
		`CHK(n, 27)
		`CHK(MEM.mem[9'h101], 16'h0F33)
		`CHK(MEM.mem[9'h100], 16'h00FF)
		if (n >= 200) results();
	endtask

	initial begin
		rst = 1'b1;
		n_waits = 4'h0;
		n_fail = 0;
		comparisons = 0;
		t_run(4'h0);
		t_run(4'h2);
		t_alu();
		results();
	end
endmodule

`default_nettype wire

// ===== testbench/stk_wb_mem.sv
/*
 * Slave memory model for the processor bus, 512 words.
 * Assumes one master; the wait count is set by the bench.
 */
`timescale 1ns/10ps
`default_nettype none

module stk_wb_mem (
	input  wire logic        i_clk_sys,
	input  wire logic        i_cyc,
	input  wire logic        i_stb,
	input  wire logic        i_we,
	input  wire logic [15:1] i_adr,
	input  wire logic [1:0]  i_sel,
	input  wire logic [15:0] i_dat,
	input  wire logic [3:0]  i_waits,
	output logic             o_ack,
	output logic      [15:0] o_dat
);
	logic [15:0] mem [512];
	logic [3:0]  wt_reg = 4'h0;
	logic [15:0] last_reg = 16'h5A5A;
	logic [8:0]  ix;
	assign ix = i_adr[9:1];

	// Decode on strobe AND cycle, ack after the chosen waits
	assign o_ack = i_cyc && i_stb && (wt_reg == i_waits);
	// Data valid with ack only; otherwise it changes every cycle
	assign o_dat = (o_ack && !i_we) ? mem[ix] : ~last_reg;

	// Wait counter and lane writes
	always @(posedge i_clk_sys) begin
		last_reg <= o_dat;
		wt_reg <= (i_cyc && i_stb && !o_ack) ? wt_reg + 4'h1 : 4'h0;
		if (o_ack && i_we && i_sel[1]) mem[ix][15:8] <= i_dat[15:8];
		if (o_ack && i_we && i_sel[0]) mem[ix][7:0] <= i_dat[7:0];
	end
endmodule

`default_nettype wire
